/* File: src/jtb_defines.svh */
// Constants for the scan test access port block
// What this block does
// - Select states idle, exit next cycle by TMS
// - Capture-DR loads selected register on exiting edge
// - Shift-DR entry: TDO drives LSB at falling
// - Shift-DR shifts each rising edge, including exit
// - Exit1-DR floats TDO; re-shift needs no recapture
// - Pause-DR holds partial shift contents indefinitely
// - Update-DR copies shift stage to shadow, falling
// - Capture-IR loads 10000001, shifted out on TDO
// - Shift-IR entry: TDO drives instruction LSB at falling
// - Shift-IR shifts each rising edge, including exit
// - Exit1-IR floats TDO; re-shift needs no recapture
// - Pause-IR holds instruction shift contents indefinitely
// - Update-IR loads instruction shadow on falling edge
// - Shift stage plus shadow; bypass/ident shift only
// - Eight-bit instruction selects mode, register, source
// - Bit 7 is parity; unsupported codes act as bypass
// - Reset forces instruction to 10000001, ident read
// - Boundary chain has 48 cells, one per pin
// - Instruction chooses boundary capture source
// - Reset sets cells 47 to 44 high
// - Chain runs input to cell 47, out cell 0
// - Cell map: enables, clocks, latches, A, B
// - Sample TMS/TDI rising, change TDO falling
// - TMS high five cycles reaches reset state
`ifndef JTB_DEFINES_SVH
`define JTB_DEFINES_SVH

`define JTB_IR_W 8
`define JTB_IR_RESET 8'h81
`define JTB_IR_CAPTURE 8'h81
`define JTB_BSR_W 48
`define JTB_ID_W 32
// Arbitrary neutral identification value
`define JTB_ID_VALUE 32'h0000_0001

`define JTB_OP_BOUNDARY_TEST 8'h00
`define JTB_OP_IDENT 8'h81
`define JTB_OP_SAMPLE 8'h82
`define JTB_OP_HIGHZ 8'h06
`define JTB_OP_CLAMP 8'h87

// Boundary cell map, upper and lower bound of each field
`define JTB_CELL_OE_HI 47
`define JTB_CELL_OE_LO 44
`define JTB_CELL_CLK_HI 43
`define JTB_CELL_CLK_LO 40
`define JTB_CELL_LE_HI 39
`define JTB_CELL_LE_LO 36
`define JTB_CELL_A_HI 35
`define JTB_CELL_A_LO 18
`define JTB_CELL_B_HI 17
`define JTB_CELL_B_LO 0
`define JTB_BSR_RESET 48'hf000_0000_0000

`define JTB_FIFO_DEPTH 2

`endif

/* File: src/jtb_pkg.sv */
// Types for the scan test access port block
package jtb_pkg;

	typedef enum logic [3:0] {
		TLR, RTI, SEL_DR, CAP_DR, SHF_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
		SEL_IR, CAP_IR, SHF_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
	} jtb_state_t;

	typedef enum logic [1:0] {
		SEL_BYPASS, SEL_BOUNDARY, SEL_IDENT
	} jtb_dsel_t;

	typedef struct packed {
		logic test_mode;
		logic highz;
		logic clamp;
		jtb_dsel_t dsel;
		logic capture_pins;
	} jtb_instr_t;

	typedef struct packed {
		logic tck;
		logic tms;
		logic tdi;
	} jtb_link_t;

endpackage

/* File: src/jtb_tap.sv */
// Test access port controller with instruction and boundary chains
`timescale 1ns/1ps
`include "jtb_defines.svh"

module jtb_tap import jtb_pkg::*; (
	input wire logic clk_i, // System clock, 100 MHz
	input wire logic arst_n_i, // Asynchronous reset, active low
	input wire logic tck_i, // Test clock pin
	input wire logic tms_i, // Test mode select pin
	input wire logic tdi_i, // Test data in pin
	output logic tdo_o, // Test data out
	output logic tdo_oe_n_o, // TDO enable, low while driven
	input wire logic [47:0] pins_i, // Boundary pin levels
	output logic [47:0] cells_o, // Boundary shadow latches
	output logic test_mode_o, // Normal logic inhibited
	output logic highz_o, // Outputs forced to high impedance
	output logic [7:0] instr_o, // Current instruction
	output logic [3:0] state_o, // Controller state
	output logic upd_valid_o, // Buffered update word present
	output logic [47:0] upd_data_o, // Buffered update word
	input wire logic upd_ready_i, // Consumer takes the word
	output logic upd_lost_o // Update dropped, buffer was full
);

	// ==========================================================
	// Pin synchronisers
	// Link pins come from another clock, so two flops each before use
	jtb_link_t link_m;
	jtb_link_t link_s;
	logic tck_d;
	logic [47:0] pins_m;
	logic [47:0] pins_s;

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			link_m <= '0;
			link_s <= '0;
			tck_d <= 1'b0;
			pins_m <= '0;
			pins_s <= '0;
		end else begin
			link_m <= '{tck: tck_i, tms: tms_i, tdi: tdi_i};
			link_s <= link_m;
			tck_d <= link_s.tck;
			pins_m <= pins_i;
			pins_s <= pins_m;
		end
	end

	// All test activity keys off these two strobes
	wire tck_rise = link_s.tck & ~tck_d;
	wire tck_fall = ~link_s.tck & tck_d;

	// ==========================================================
	// Controller
	jtb_state_t state;
	jtb_state_t next_state;

	always_comb begin
		next_state = state;
		case (state)
			TLR: next_state = link_s.tms ? TLR : RTI;
			RTI: next_state = link_s.tms ? SEL_DR : RTI;
			SEL_DR: next_state = link_s.tms ? SEL_IR : CAP_DR;
			CAP_DR: next_state = link_s.tms ? EX1_DR : SHF_DR;
			SHF_DR: next_state = link_s.tms ? EX1_DR : SHF_DR;
			EX1_DR: next_state = link_s.tms ? UPD_DR : PAU_DR;
			PAU_DR: next_state = link_s.tms ? EX2_DR : PAU_DR;
			EX2_DR: next_state = link_s.tms ? UPD_DR : SHF_DR;
			UPD_DR: next_state = link_s.tms ? SEL_DR : RTI;
			SEL_IR: next_state = link_s.tms ? TLR : CAP_IR;
			CAP_IR: next_state = link_s.tms ? EX1_IR : SHF_IR;
			SHF_IR: next_state = link_s.tms ? EX1_IR : SHF_IR;
			EX1_IR: next_state = link_s.tms ? UPD_IR : PAU_IR;
			PAU_IR: next_state = link_s.tms ? EX2_IR : PAU_IR;
			EX2_IR: next_state = link_s.tms ? UPD_IR : SHF_IR;
			UPD_IR: next_state = link_s.tms ? SEL_DR : RTI;
			default: next_state = TLR;
		endcase
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state <= TLR;
		end else if (tck_rise) begin
			state <= next_state;
		end
	end

	// ==========================================================
	// Instruction decode
	// Full eight-bit compare: a code with bad parity matches nothing
	// and so falls through to bypass.
	function automatic jtb_instr_t decode(input logic [7:0] op);
		jtb_instr_t d;
		d = '{test_mode: 1'b0, highz: 1'b0, clamp: 1'b0, dsel: SEL_BYPASS,
			capture_pins: 1'b0};
		case (op)
			`JTB_OP_BOUNDARY_TEST: begin
				d.test_mode = 1'b1;
				d.dsel = SEL_BOUNDARY;
				d.capture_pins = 1'b1;
			end
			`JTB_OP_IDENT: d.dsel = SEL_IDENT;
			`JTB_OP_SAMPLE: begin
				d.dsel = SEL_BOUNDARY;
				d.capture_pins = 1'b1;
			end
			`JTB_OP_HIGHZ: begin
				d.test_mode = 1'b1;
				d.highz = 1'b1;
			end
			`JTB_OP_CLAMP: begin
				d.test_mode = 1'b1;
				d.clamp = 1'b1;
			end
			default: d.dsel = SEL_BYPASS;
		endcase
		return d;
	endfunction

	logic [7:0] ir_shift;
	logic [7:0] ir_shadow;
	wire jtb_instr_t cur = decode(ir_shadow);

	// ==========================================================
	// Shift stages, captured and shifted on TCK rising edges
	logic [47:0] bsr_shift;
	logic [31:0] id_shift;
	logic bypass_shift;

	wire in_tlr = (state == TLR);
	wire cap_dr = tck_rise & (state == CAP_DR);
	wire shf_dr = tck_rise & (state == SHF_DR);
	wire cap_ir = tck_rise & (state == CAP_IR);
	wire shf_ir = tck_rise & (state == SHF_IR);
	wire sel_bsr = (cur.dsel == SEL_BOUNDARY);
	wire sel_id = (cur.dsel == SEL_IDENT);
	wire sel_byp = (cur.dsel == SEL_BYPASS);
	// Cell map: enables, store clocks, latch enables, A port, B port.
	// Reset loads all ones into the enable field and zeros elsewhere, so that a
	// later switch to test mode leaves both ports floating.
	wire [3:0] pin_enables = pins_s[`JTB_CELL_OE_HI:`JTB_CELL_OE_LO];
	wire [3:0] pin_clocks = pins_s[`JTB_CELL_CLK_HI:`JTB_CELL_CLK_LO];
	wire [3:0] pin_latches = pins_s[`JTB_CELL_LE_HI:`JTB_CELL_LE_LO];
	wire [17:0] pin_a_port = pins_s[`JTB_CELL_A_HI:`JTB_CELL_A_LO];
	wire [17:0] pin_b_port = pins_s[`JTB_CELL_B_HI:`JTB_CELL_B_LO];
	wire [47:0] pin_word = {pin_enables, pin_clocks, pin_latches, pin_a_port, pin_b_port};
	// Capture source for boundary chain depends on the instruction
	wire [47:0] bsr_capture = cur.capture_pins ? pin_word : bsr_shift;

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ir_shift <= `JTB_IR_RESET;
		end else if (in_tlr) begin
			ir_shift <= `JTB_IR_RESET;
		end else if (cap_ir) begin
			ir_shift <= `JTB_IR_CAPTURE;
		end else if (shf_ir) begin
			ir_shift <= {link_s.tdi, ir_shift[7:1]};
		end
	end

	// Each cell chooses reset, capture, shift or hold for itself; pause
	// and exit states hold, so a suspended scan loses nothing.
	localparam logic [47:0] bsr_reset_value = `JTB_BSR_RESET;
	wire bsr_load = cap_dr & sel_bsr;
	wire bsr_step = shf_dr & sel_bsr;
	wire [48:0] bsr_chain = {link_s.tdi, bsr_shift};
	wire [47:0] next_bsr;

	for (genvar gi = 0; gi < `JTB_BSR_W; gi++) begin : g_cell
		assign next_bsr[gi] = in_tlr ? bsr_reset_value[gi] :
			(bsr_load ? bsr_capture[gi] : (bsr_step ? bsr_chain[gi + 1] : bsr_shift[gi]));
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			bsr_shift <= `JTB_BSR_RESET;
		end else begin
			bsr_shift <= next_bsr;
		end
	end

	// Bypass and ident are single-stage: no shadow behind them
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			id_shift <= '0;
			bypass_shift <= 1'b0;
		end else begin
			if (cap_dr && sel_id) begin
				id_shift <= `JTB_ID_VALUE;
			end else if (shf_dr && sel_id) begin
				id_shift <= {link_s.tdi, id_shift[31:1]};
			end
			if (cap_dr && sel_byp) begin
				bypass_shift <= 1'b0;
			end else if (shf_dr && sel_byp) begin
				bypass_shift <= link_s.tdi;
			end
		end
	end

	// ==========================================================
	// Shadows and TDO, changed on TCK falling edges
	wire upd_dr = tck_fall & (state == UPD_DR) & sel_bsr;
	wire upd_ir = tck_fall & (state == UPD_IR);
	wire dr_lsb = sel_bsr ? bsr_shift[0] : (sel_id ? id_shift[0] : bypass_shift);
	wire shifting = (state == SHF_DR) | (state == SHF_IR);
	wire next_tdo = (state == SHF_IR) ? ir_shift[0] : dr_lsb;

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ir_shadow <= `JTB_IR_RESET;
			cells_o <= `JTB_BSR_RESET;
		end else if (in_tlr) begin
			ir_shadow <= `JTB_IR_RESET;
			cells_o <= `JTB_BSR_RESET;
		end else begin
			if (upd_ir) begin
				ir_shadow <= ir_shift;
			end
			if (upd_dr) begin
				cells_o <= bsr_shift;
			end
		end
	end

	// Enable goes active on the first falling edge in a shift state
	// and releases on the first falling edge after leaving it.
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			tdo_o <= 1'b0;
			tdo_oe_n_o <= 1'b1;
		end else if (tck_fall) begin
			tdo_o <= next_tdo;
			tdo_oe_n_o <= ~shifting;
		end
	end

	// Mode outputs follow the shadow, so they change at the update edge
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			test_mode_o <= 1'b0;
			highz_o <= 1'b0;
			instr_o <= `JTB_IR_RESET;
			state_o <= '0;
		end else begin
			test_mode_o <= cur.test_mode;
			highz_o <= cur.highz;
			instr_o <= ir_shadow;
			state_o <= state;
		end
	end

	// ==========================================================
	// Two-entry update buffer
	// Each boundary update is offered to the consumer. The head entry
	// is the output register; a full buffer refuses and flags the loss
	// rather than stalling the scan, since TCK cannot be held off.
	logic [47:0] slot1;
	logic valid1;
	wire fifo_ready = ~valid1;
	wire push = upd_dr & fifo_ready;
	wire pop = upd_valid_o & upd_ready_i;

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			upd_valid_o <= 1'b0;
			upd_data_o <= '0;
			valid1 <= 1'b0;
			slot1 <= '0;
			upd_lost_o <= 1'b0;
		end else begin
			upd_lost_o <= upd_dr & ~fifo_ready;
			if (pop) begin
				if (valid1) begin
					upd_data_o <= slot1;
					valid1 <= push;
					slot1 <= bsr_shift;
				end else begin
					upd_valid_o <= push;
					upd_data_o <= bsr_shift;
				end
			end else if (push) begin
				if (!upd_valid_o) begin
					upd_data_o <= bsr_shift;
					upd_valid_o <= 1'b1;
				end else begin
					slot1 <= bsr_shift;
					valid1 <= 1'b1;
				end
			end
		end
	end

endmodule

/* File: bench/jtb_ctrl.sv */
// Test controller model driving the scan link of the block
`timescale 1ns/1ps
module jtb_ctrl (
	input wire logic clk_i, // Bench clock
	input wire logic tdo_i, // Data from the block
	input wire logic tdo_oe_n_i, // TDO enable from the block, low while driven
	output logic tck_o, // Test clock, low between frames
	output logic tms_o, // Mode select
	output logic tdi_o // Data into the block
);
	// ==========
	// Link cycles
	initial begin
		tck_o = 1'b0;
		tms_o = 1'b1;
		tdi_o = 1'b1;
	end
	// One 160 ns test clock; inputs held well past the rise for the sync delay
	task step(input logic tms, input logic tdi, output logic tdo);
		@(negedge clk_i);
		tms_o = tms;
		tdi_o = tdi;
		repeat (4) @(negedge clk_i);
		// No pull on TDO: a released pin reads as the inverse of its last level
		tdo = tdo_oe_n_i ? ~tdo_i : tdo_i;
		tck_o = 1'b1;
		repeat (8) @(negedge clk_i);
		tck_o = 1'b0;
		repeat (3) @(negedge clk_i);
	endtask
	// Full scan from Run-Test/Idle back to it; idle TDI sits at its pull-up level
	task scan(input logic ir, input int n, input logic [47:0] din, output logic [47:0] dout);
		logic t;
		dout = '0;
		step(1'b1, 1'b1, t);
		if (ir) step(1'b1, 1'b1, t);
		step(1'b0, 1'b1, t);
		step(1'b0, 1'b1, t);
		for (int i = 0; i < n; i++) step(i == n - 1, din[i], dout[i]);
		step(1'b1, 1'b1, t);
		step(1'b0, 1'b1, t);
	endtask
endmodule

/* File: bench/jtb_tap_sva.sv */
// Concurrent checks on the scan port block
`timescale 1ns/1ps
module jtb_tap_sva import jtb_pkg::*; (
	input wire logic clk_i, // Clock
	input wire logic arst_n_i, // Reset, active low
	input wire logic tdo_oe_n_o, // TDO enable
	input wire logic [47:0] cells_o, // Shadow cells
	input wire logic test_mode_o, // Test mode
	input wire logic highz_o, // High impedance
	input wire logic [7:0] instr_o, // Instruction
	input wire logic [3:0] state_o, // State
	input wire logic upd_valid_o, // Buffer valid
	input wire logic [47:0] upd_data_o, // Buffer head
	input wire logic upd_ready_i, // Buffer ready
	input wire logic upd_lost_o // Word dropped
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!arst_n_i);
	// ==========
	// Properties
	property p_oe_on;
		$fell(tdo_oe_n_o) |-> state_o inside {SHF_DR, SHF_IR};
	endproperty
	a_oe_on: assert property (p_oe_on) else $error("TDO enabled outside shift");
	property p_oe_off;
		$rose(tdo_oe_n_o) |-> state_o inside {EX1_DR, EX1_IR};
	endproperty
	a_oe_off: assert property (p_oe_off) else $error("TDO released outside exit");
	property p_sel_dr;
		$past(state_o) == SEL_DR && state_o != SEL_DR |-> state_o inside {CAP_DR, SEL_IR};
	endproperty
	a_sel_dr: assert property (p_sel_dr) else $error("bad exit from data select");
	property p_sel_ir;
		$past(state_o) == SEL_IR && state_o != SEL_IR |-> state_o inside {CAP_IR, TLR};
	endproperty
	a_sel_ir: assert property (p_sel_ir) else $error("bad exit from instr select");
	property p_tlr;
		state_o == TLR [*3] |-> instr_o == 8'h81 && cells_o[47:44] == 4'hf;
	endproperty
	a_tlr: assert property (p_tlr) else $error("reset state values wrong");
	property p_instr;
		$changed(instr_o) |-> state_o inside {UPD_IR, TLR};
	endproperty
	a_instr: assert property (p_instr) else $error("instruction changed off update");
	property p_cells;
		$changed(cells_o) |-> state_o inside {UPD_DR, TLR};
	endproperty
	a_cells: assert property (p_cells) else $error("cells changed off update");
	property p_highz;
		instr_o == 8'h06 [*2] |-> highz_o && test_mode_o;
	endproperty
	a_highz: assert property (p_highz) else $error("highz mode not set");
	property p_normal;
		instr_o inside {8'h81, 8'h82, 8'h01} [*2] |-> !test_mode_o && !highz_o;
	endproperty
	a_normal: assert property (p_normal) else $error("normal mode not kept");
	property p_hold;
		upd_valid_o && !upd_ready_i |=> upd_valid_o && $stable(upd_data_o);
	endproperty
	a_hold: assert property (p_hold) else $error("buffer head not held");
	property p_lost;
		upd_lost_o |-> $past(upd_valid_o) ##1 !upd_lost_o;
	endproperty
	a_lost: assert property (p_lost) else $error("bad drop pulse");
	c_pause: cover property (state_o == PAU_IR);
	c_lost: cover property (upd_lost_o);
	c_highz: cover property (highz_o);
endmodule
bind jtb_tap jtb_tap_sva i_jtb_tap_sva (.*);

/* File: bench/tb_top.sv */
// Self-checking bench for the scan port block
`timescale 1ns/1ps
`include "jtb_defines.svh"
module tb_top import jtb_pkg::*; ;
	logic clk, arst_n, tck, tms, tdi, tdo, oe_n, tmode, hz, uv, ur, ul;
	logic [47:0] pins, cells, ud;
	logic [7:0] instr;
	logic [3:0] st;
	int num_errors = 0;
	int samples_checked = 0;
	int lost_seen = 0;
	// Drop pulses last one clock, so a falling-edge count sees each once
	always @(negedge clk) begin
		if (ul === 1'b1) lost_seen++;
	end
	jtb_tap i_jtb_tap (.clk_i(clk), .arst_n_i(arst_n), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
		.tdo_o(tdo), .tdo_oe_n_o(oe_n), .pins_i(pins), .cells_o(cells), .test_mode_o(tmode),
		.highz_o(hz), .instr_o(instr), .state_o(st), .upd_valid_o(uv), .upd_data_o(ud),
		.upd_ready_i(ur), .upd_lost_o(ul));
	jtb_ctrl i_jtb_ctrl (.clk_i(clk), .tdo_i(tdo), .tdo_oe_n_i(oe_n), .tck_o(tck), .tms_o(tms),
		.tdi_o(tdi));
	// ==========
	// Helpers
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task chk(input string name, input logic [47:0] exp, input logic [47:0] got);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("FAIL %s expected %h seen %h", name, exp, got);
		end
	endtask
	task s(input logic m);
		logic t;
		i_jtb_ctrl.step(m, 1'b1, t);
	endtask
	task results;
		$display("errors %0d checks %0d", num_errors, samples_checked);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// ==========
	// Scenarios
	task t_reset;
		logic [47:0] d;
		repeat (5) s(1'b1);
		chk("state", TLR, st);
		chk("instr", 8'h81, instr);
		chk("oe_cells", 4'hf, cells[47:44]);
		s(1'b0);
		i_jtb_ctrl.scan(1'b0, 32, 48'h0, d);
		chk("ident", `JTB_ID_VALUE, d[31:0]);
		$display("t_reset done");
	endtask
	task t_dr;
		logic [47:0] d;
		i_jtb_ctrl.scan(1'b1, 8, 48'h82, d);
		chk("ir_capture", 8'h81, d[7:0]);
		chk("instr", 8'h82, instr);
		chk("test_mode", 1'b0, tmode);
		i_jtb_ctrl.scan(1'b0, 48, 48'ha5c3_1234_f00f, d);
		chk("dr_capture", pins, d);
		chk("cells", 48'ha5c3_1234_f00f, cells);
		chk("upd_data", 48'ha5c3_1234_f00f, ud);
		$display("t_dr done");
	endtask
	// Receiver stalls while two more words arrive; the last one must be dropped
	task t_buf;
		logic [47:0] d;
		pins = 48'h0123_4567_89ab;
		i_jtb_ctrl.scan(1'b0, 48, 48'h1111_2222_3333, d);
		chk("dr_capture2", 48'h0123_4567_89ab, d);
		i_jtb_ctrl.scan(1'b0, 48, 48'h4444_5555_6666, d);
		chk("head_held", 48'ha5c3_1234_f00f, ud);
		chk("lost", 1, lost_seen);
		@(negedge clk);
		ur = 1'b1;
		@(negedge clk);
		chk("second", 48'h1111_2222_3333, ud);
		@(negedge clk);
		chk("drained", 1'b0, uv);
		ur = 1'b0;
		$display("t_buf done");
	endtask
	task t_byp;
		logic [47:0] d;
		i_jtb_ctrl.scan(1'b1, 8, 48'h01, d);
		chk("instr_bad", 8'h01, instr);
		i_jtb_ctrl.scan(1'b0, 2, 48'h1, d);
		chk("bypass", 2'b10, d[1:0]);
		chk("cells_kept", 48'h4444_5555_6666, cells);
		$display("t_byp done");
	endtask
	task t_pause;
		logic [7:0] d;
		logic [7:0] v;
		v = 8'h06;
		s(1'b1);
		s(1'b1);
		s(1'b0);
		s(1'b0);
		for (int i = 0; i < 8; i++) begin
			i_jtb_ctrl.step(i == 3 || i == 7, v[i], d[i]);
			if (i == 3) begin
				repeat (3) s(1'b0);
				chk("pause", PAU_IR, st);
				chk("oe_pause", 1'b1, oe_n);
				s(1'b1);
				s(1'b0);
			end
		end
		s(1'b1);
		s(1'b0);
		chk("ir_resume", 8'h81, d);
		chk("instr", 8'h06, instr);
		chk("highz", 1'b1, hz);
		$display("t_pause done");
	endtask
	// Test-mode codes, then a forced return to reset from inside a data scan
	task t_ext;
		logic [47:0] d;
		i_jtb_ctrl.scan(1'b1, 8, 48'h87, d);
		chk("ir_capture2", 8'h81, d[7:0]);
		chk("clamp_mode", 1'b1, tmode);
		chk("clamp_hz", 1'b0, hz);
		i_jtb_ctrl.scan(1'b1, 8, 48'h00, d);
		chk("ext_instr", 8'h00, instr);
		chk("ext_mode", 1'b1, tmode);
		s(1'b1);
		s(1'b0);
		s(1'b0);
		repeat (5) s(1'b1);
		chk("state_tlr", TLR, st);
		chk("instr_tlr", 8'h81, instr);
		chk("oe_cells_tlr", 4'hf, cells[47:44]);
		chk("mode_tlr", 1'b0, tmode);
		s(1'b0);
		$display("t_ext done");
	endtask
	// ==========
	// Main sequence
	initial begin
		arst_n = 1'b0;
		ur = 1'b0;
		pins = 48'h5a5a_c3c3_0f0f;
		repeat (2) @(posedge clk);
		@(negedge clk);
		arst_n = 1'b1;
		s(1'b0);
		t_reset;
		t_dr;
		t_buf;
		t_byp;
		t_pause;
		t_ext;
		results;
	end
	// A hung link would otherwise never reach the report
	initial begin
		#200000;
		num_errors++;
		results;
	end
endmodule
